// ==== include/sbct_defines.vh ====
/*
 constants for the sixteen-bit capture timer: register offsets, field
 positions, reset values, mode codes and filter length.
 assumes inclusion by bare name from the design file.
*/
`ifndef SBCT_DEFINES_VH
`define SBCT_DEFINES_VH
`define SBCT_OFS_CTRL_MAIN    4'h0
`define SBCT_OFS_CTRL_MODE    4'h1
`define SBCT_OFS_EVENT_CTRL   4'h4
`define SBCT_OFS_INT_ENABLE   4'h5
`define SBCT_OFS_INT_FLAG     4'h6
`define SBCT_OFS_RUN_STATE    4'h7
`define SBCT_OFS_DEBUG        4'h8
`define SBCT_OFS_WIDE_BUF     4'h9
`define SBCT_OFS_CNT_LO       4'hA
`define SBCT_OFS_CNT_HI       4'hB
`define SBCT_OFS_CMP_LO       4'hC
`define SBCT_OFS_CMP_HI       4'hD
`define SBCT_BIT_ENABLE       0
`define SBCT_BIT_SYNC_RESTART 4
`define SBCT_BIT_STANDBY_RUN  6
`define SBCT_BIT_CLK_LO       1
`define SBCT_BIT_CLK_HI       2
`define SBCT_BIT_MODE_LO      0
`define SBCT_BIT_MODE_HI      2
`define SBCT_BIT_OUT_EN       4
`define SBCT_BIT_OUT_INIT     5
`define SBCT_BIT_ASYNC        6
`define SBCT_BIT_EV_EN        0
`define SBCT_BIT_EDGE         4
`define SBCT_BIT_FILTER       6
`define SBCT_MASK_CTRL_MAIN   8'h57
`define SBCT_MASK_CTRL_MODE   8'h77
`define SBCT_MASK_EVENT_CTRL  8'h51
`define SBCT_MASK_BIT0        8'h01
`define SBCT_RESET_BYTE       8'h00
`define SBCT_RESET_WORD       16'h0000
`define SBCT_CLK_UNDIVIDED    2'h0
`define SBCT_CLK_HALF         2'h1
`define SBCT_CLK_COMPANION    2'h2
`define SBCT_MODE_PERIODIC    3'h0
`define SBCT_MODE_TIMEOUT     3'h1
`define SBCT_MODE_CAPTURE     3'h2
`define SBCT_MODE_FREQ        3'h3
`define SBCT_MODE_WIDTH       3'h4
`define SBCT_MODE_FREQ_WIDTH  3'h5
`define SBCT_MODE_SINGLE      3'h6
`define SBCT_MODE_BYTE_PWM    3'h7
`define SBCT_FILTER_LEN       4
`endif

// ==== verilog/sbct_timer.v ====
/*
 sixteen-bit capture timer with avalon-mm register slave, event edge
 actions, noise filter and waveform output.
 assumes synchronous event, companion tick, restart and standby inputs;
 byte-wide registers each on one aligned 32-bit word.
*/
`timescale 1ns/10ps
`default_nettype none
// Overview of operation
// RULE1 - standby_run keeps timer going in standby; ignored with companion clock
// RULE2 - sync_restart restarts counter when companion timer restarts or overflows
// RULE3 - clock_choice: 0 peripheral, 1 half, 2 companion tick, 3 reserved
// RULE4 - enable bit 0 of control_main switches the timer on
// RULE5 - single-shot async bit: output high at event, else at counter start
// RULE6 - output_initial_level sets idle pin level, ignored in pwm and single
// RULE7 - waveform_output_enable lets timer drive the pin, else not driven
// RULE8 - counter_mode field picks one of eight modes
// RULE9 - filter bit enables four-sample noise filter before edge detect
// RULE10 - periodic and byte pwm modes ignore event edges
// RULE11 - timeout: selected edge starts counter, other edge stops it
// RULE12 - capture mode: selected edge copies count, raises capture_flag
// RULE13 - frequency mode: selected edge captures, clears, restarts, flags
// RULE14 - pulse width: one edge clears and restarts, other captures and flags
// RULE15 - freq plus width: restart, capture, then stop and flag
// RULE16 - single-shot: edge bit 0 rising starts, bit 1 both edges start
// RULE17 - event_input_enable gates all event actions
// RULE18 - capture_flag clears on write one or capture register read
// RULE19 - run_state bit reads one while counting, read-only
// RULE20 - byte pwm: low compare byte is period, high byte is duty
// RULE21 - counter ticks on selected clock; compare acts as top in timer modes
`include "sbct_defines.vh"
module sbct_timer (
    input  wire        clk,
    input  wire        rst_b,
    input  wire [5:0]  avs_address,
    input  wire        avs_read,
    input  wire        avs_write,
    input  wire [31:0] avs_writedata,
    input  wire [3:0]  avs_byteenable,
    output reg  [31:0] avs_readdata,
    output reg         avs_waitrequest,
    input  wire        event_in,
    input  wire        companion_tick,
    input  wire        companion_restart,
    input  wire        standby,
    output reg         wave_out,
    output reg         wave_oe_b,
    output reg         capture_event
);
    reg  [7:0]  control_main;
    reg  [7:0]  control_mode_output;
    reg  [7:0]  event_control;
    reg  [7:0]  interrupt_enable;
    reg         capture_flag;
    reg  [7:0]  debug_behaviour;
    reg  [7:0]  wide_access_buffer;
    reg  [15:0] counter_value;
    reg  [15:0] capture_compare_value;
    reg         running;
    reg         half_phase;
    reg         width_armed;
    reg         wave_level;
    reg         ack;
    reg  [`SBCT_FILTER_LEN-1:0] samples;
    reg         filtered;
    reg         ev_prev;

    wire [3:0] index = avs_address[5:2];
    // write lands on the edge that completes the transfer
    wire       wr_lane = avs_write & avs_byteenable[0] & ack;
    wire       rd_now = avs_read & ~ack;
    wire [1:0] clock_choice = control_main[`SBCT_BIT_CLK_HI:`SBCT_BIT_CLK_LO];
    wire [2:0] counter_mode =
        control_mode_output[`SBCT_BIT_MODE_HI:`SBCT_BIT_MODE_LO];
    wire       edge_sel = event_control[`SBCT_BIT_EDGE];
    wire       standby_run = control_main[`SBCT_BIT_STANDBY_RUN];
    wire       output_initial_level = control_mode_output[`SBCT_BIT_OUT_INIT];
    wire       waveform_output_enable = control_mode_output[`SBCT_BIT_OUT_EN];
    wire       async_out = control_mode_output[`SBCT_BIT_ASYNC];

    // standby halts only derived clocks; companion clock follows its owner
    wire halted = standby & ~(standby_run |
                  (clock_choice == `SBCT_CLK_COMPANION)); // RULE1
    wire active = control_main[`SBCT_BIT_ENABLE] & ~halted; // RULE4

    reg tick;
    always @* begin
        case (clock_choice) // RULE3
            `SBCT_CLK_UNDIVIDED: tick = 1'b1;
            `SBCT_CLK_HALF:      tick = half_phase;
            `SBCT_CLK_COMPANION: tick = companion_tick;
            default:             tick = 1'b0;
        endcase
    end

    // noise filter: input accepted once four samples agree
    wire all_one  = &samples;
    wire all_zero = ~|samples;
    wire ev_level = event_control[`SBCT_BIT_FILTER] ? filtered
                                                    : event_in; // RULE9
    wire ev_ok  = active & event_control[`SBCT_BIT_EV_EN]; // RULE17
    wire rise   = ev_ok & ev_level & ~ev_prev;
    wire fall   = ev_ok & ~ev_level & ev_prev;
    wire sel_e  = edge_sel ? fall : rise;
    wire oth_e  = edge_sel ? rise : fall;

    wire pwm      = counter_mode == `SBCT_MODE_BYTE_PWM;
    wire [15:0] top = pwm ? {8'h00, capture_compare_value[7:0]}
                          : capture_compare_value; // RULE21 RULE20
    wire at_top   = counter_value == top;

    reg        next_run;
    reg [15:0] next_cnt;
    reg [15:0] next_cmp;
    reg        next_flag_set;
    reg        next_armed;
    reg        ev_start;
    always @* begin
        next_run = running;
        next_cnt = counter_value;
        next_cmp = capture_compare_value;
        next_flag_set = 1'b0;
        next_armed = width_armed;
        ev_start = 1'b0;
        if (active && running && tick) begin
            if (at_top && counter_mode != `SBCT_MODE_CAPTURE &&
                counter_mode != `SBCT_MODE_FREQ &&
                counter_mode != `SBCT_MODE_WIDTH &&
                counter_mode != `SBCT_MODE_FREQ_WIDTH) begin
                next_cnt = `SBCT_RESET_WORD;
                next_flag_set = 1'b1;
                if (counter_mode == `SBCT_MODE_SINGLE ||
                    counter_mode == `SBCT_MODE_TIMEOUT)
                    next_run = 1'b0;
            end else begin
                next_cnt = counter_value + 16'h0001; // RULE21
            end
        end
        case (counter_mode) // RULE8 RULE10
            `SBCT_MODE_TIMEOUT: begin
                if (sel_e) begin // RULE11
                    next_run = 1'b1;
                    next_cnt = `SBCT_RESET_WORD;
                end else if (oth_e)
                    next_run = 1'b0;
            end
            `SBCT_MODE_CAPTURE: begin
                // free-running count, so each capture has a time base
                next_run = 1'b1;
                if (sel_e) begin // RULE12
                    next_cmp = counter_value;
                    next_flag_set = 1'b1;
                end
            end
            `SBCT_MODE_FREQ: begin
                if (sel_e) begin // RULE13
                    next_cmp = counter_value;
                    next_cnt = `SBCT_RESET_WORD;
                    next_run = 1'b1;
                    next_flag_set = 1'b1;
                end
            end
            `SBCT_MODE_WIDTH: begin
                if (sel_e) begin // RULE14
                    next_cnt = `SBCT_RESET_WORD;
                    next_run = 1'b1;
                end else if (oth_e) begin
                    next_cmp = counter_value;
                    next_flag_set = 1'b1;
                end
            end
            `SBCT_MODE_FREQ_WIDTH: begin
                if (sel_e && !width_armed) begin // RULE15
                    next_cnt = `SBCT_RESET_WORD;
                    next_run = 1'b1;
                    next_armed = 1'b1;
                end else if (sel_e) begin
                    next_run = 1'b0;
                    next_armed = 1'b0;
                    next_flag_set = 1'b1;
                end else if (oth_e && width_armed)
                    next_cmp = counter_value;
            end
            `SBCT_MODE_SINGLE: begin
                if ((rise || (edge_sel && fall)) && !running) begin // RULE16
                    next_run = 1'b1;
                    next_cnt = `SBCT_RESET_WORD;
                    ev_start = 1'b1;
                end
            end
            default: begin
                next_run = 1'b1;
            end
        endcase
        if (!control_main[`SBCT_BIT_ENABLE])
            next_run = 1'b0;
        if (active && control_main[`SBCT_BIT_SYNC_RESTART] &&
            companion_restart)
            next_cnt = `SBCT_RESET_WORD; // RULE2
    end

    reg next_wave;
    always @* begin
        next_wave = wave_level;
        if (counter_mode == `SBCT_MODE_SINGLE) begin
            if (ev_start && async_out)
                next_wave = 1'b1; // RULE5
            else if (running && !async_out)
                next_wave = 1'b1;
            if (!next_run)
                next_wave = 1'b0;
        end else if (pwm)
            next_wave = running &&
                (counter_value[7:0] < capture_compare_value[15:8]); // RULE20
        else if (!running)
            next_wave = output_initial_level; // RULE6
    end

    reg [7:0] rd_byte;
    always @* begin
        case (index)
            `SBCT_OFS_CTRL_MAIN:  rd_byte = control_main;
            `SBCT_OFS_CTRL_MODE:  rd_byte = control_mode_output;
            `SBCT_OFS_EVENT_CTRL: rd_byte = event_control;
            `SBCT_OFS_INT_ENABLE: rd_byte = interrupt_enable;
            `SBCT_OFS_INT_FLAG:   rd_byte = {7'h00, capture_flag};
            `SBCT_OFS_RUN_STATE:  rd_byte = {7'h00, running}; // RULE19
            `SBCT_OFS_DEBUG:      rd_byte = debug_behaviour;
            `SBCT_OFS_WIDE_BUF:   rd_byte = wide_access_buffer;
            `SBCT_OFS_CNT_LO:     rd_byte = counter_value[7:0];
            `SBCT_OFS_CNT_HI:     rd_byte = counter_value[15:8];
            `SBCT_OFS_CMP_LO:     rd_byte = capture_compare_value[7:0];
            `SBCT_OFS_CMP_HI:     rd_byte = capture_compare_value[15:8];
            default:              rd_byte = `SBCT_RESET_BYTE;
        endcase
    end

    wire cap_mode = counter_mode == `SBCT_MODE_CAPTURE ||
                    counter_mode == `SBCT_MODE_FREQ ||
                    counter_mode == `SBCT_MODE_WIDTH ||
                    counter_mode == `SBCT_MODE_FREQ_WIDTH;
    wire cap_read = rd_now && cap_mode && (index == `SBCT_OFS_CMP_LO ||
                    index == `SBCT_OFS_CMP_HI);
    wire flag_clr = cap_read || (wr_lane && index == `SBCT_OFS_INT_FLAG &&
                    avs_writedata[0]); // RULE18
    wire [7:0] wd = avs_writedata[7:0];

    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            control_main <= `SBCT_RESET_BYTE;
            control_mode_output <= `SBCT_RESET_BYTE;
            event_control <= `SBCT_RESET_BYTE;
            interrupt_enable <= `SBCT_RESET_BYTE;
            debug_behaviour <= `SBCT_RESET_BYTE;
            wide_access_buffer <= `SBCT_RESET_BYTE;
            capture_flag <= 1'b0;
            counter_value <= `SBCT_RESET_WORD;
            capture_compare_value <= `SBCT_RESET_WORD;
            running <= 1'b0;
            half_phase <= 1'b0;
            width_armed <= 1'b0;
            wave_level <= 1'b0;
            samples <= {`SBCT_FILTER_LEN{1'b0}};
            filtered <= 1'b0;
            ev_prev <= 1'b0;
            ack <= 1'b0;
            avs_readdata <= 32'h00000000;
            avs_waitrequest <= 1'b1;
            wave_out <= 1'b0;
            wave_oe_b <= 1'b1;
            capture_event <= 1'b0;
        end else begin
            half_phase <= active ? ~half_phase : 1'b0;
            samples <= {samples[`SBCT_FILTER_LEN-2:0], event_in};
            if (all_one)
                filtered <= 1'b1;
            else if (all_zero)
                filtered <= 1'b0;
            ev_prev <= ev_level;
            running <= next_run;
            width_armed <= next_armed;
            wave_level <= next_wave;
            counter_value <= next_cnt;
            capture_compare_value <= next_cmp;
            // set wins over a simultaneous clear
            if (next_flag_set)
                capture_flag <= 1'b1;
            else if (flag_clr)
                capture_flag <= 1'b0;
            capture_event <= next_flag_set;
            wave_out <= waveform_output_enable & wave_level; // RULE7
            wave_oe_b <= ~waveform_output_enable; // RULE7
            // one wait cycle, then acknowledge; ack blocks a repeat action
            ack <= (avs_read | avs_write) & ~ack;
            avs_waitrequest <= ~((avs_read | avs_write) & ~ack);
            if (rd_now)
                avs_readdata <= {24'h000000, rd_byte};
            if (wr_lane) begin
                case (index)
                    `SBCT_OFS_CTRL_MAIN:
                        control_main <= wd & `SBCT_MASK_CTRL_MAIN;
                    `SBCT_OFS_CTRL_MODE:
                        control_mode_output <= wd & `SBCT_MASK_CTRL_MODE;
                    `SBCT_OFS_EVENT_CTRL:
                        event_control <= wd & `SBCT_MASK_EVENT_CTRL;
                    `SBCT_OFS_INT_ENABLE:
                        interrupt_enable <= wd & `SBCT_MASK_BIT0;
                    `SBCT_OFS_DEBUG:
                        debug_behaviour <= wd & `SBCT_MASK_BIT0;
                    `SBCT_OFS_WIDE_BUF: wide_access_buffer <= wd;
                    // software write beats the internal update
                    `SBCT_OFS_CNT_LO: counter_value[7:0] <= wd;
                    `SBCT_OFS_CNT_HI: counter_value[15:8] <= wd;
                    `SBCT_OFS_CMP_LO: capture_compare_value[7:0] <= wd;
                    `SBCT_OFS_CMP_HI: capture_compare_value[15:8] <= wd;
                    default: ;
                endcase
            end
        end
    end
endmodule
`default_nettype wire

// ==== bench/sbct_timer_properties.sv ====
/*
 port checker for sbct_timer, bound to every instance.
 assumes one clock domain and the registered bus answer of the slave.
*/
`timescale 1ns/10ps
`default_nettype none
module sbct_timer_properties (
    input wire logic        clk,
    input wire logic        rst_b,
    input wire logic [5:0]  avs_address,
    input wire logic        avs_read,
    input wire logic        avs_write,
    input wire logic [31:0] avs_readdata,
    input wire logic        avs_waitrequest,
    input wire logic        wave_out,
    input wire logic        wave_oe_b,
    input wire logic        capture_event
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_b);
    wire [3:0] ix = avs_address[5:2];
    wire       rdok = avs_read && !avs_waitrequest;
    property p_wait_resp;
        (avs_read || avs_write) && avs_waitrequest |-> ##[0:2] !avs_waitrequest;
    endproperty
    property p_wait_pulse; !avs_waitrequest |=> avs_waitrequest; endproperty
    property p_wait_cause;
        $fell(avs_waitrequest) |-> $past(avs_read || avs_write);
    endproperty
    property p_main_bits; rdok && ix == 4'h0 |-> !(avs_readdata & ~32'h57); endproperty
    property p_mode_bits; rdok && ix == 4'h1 |-> !(avs_readdata & ~32'h77); endproperty
    property p_evt_bits; rdok && ix == 4'h4 |-> !(avs_readdata & ~32'h51); endproperty
    property p_flag_bits; rdok && ix == 4'h6 |-> avs_readdata[31:1] == 0; endproperty
    property p_run_bits; rdok && ix == 4'h7 |-> avs_readdata[31:1] == 0; endproperty
    property p_pin_idle; wave_oe_b |-> !wave_out; endproperty
    a_wait_resp: assert property (p_wait_resp)
        else $error("no bus answer");
    a_wait_pulse: assert property (p_wait_pulse)
        else $error("answer too long");
    a_wait_cause: assert property (p_wait_cause)
        else $error("answer without request");
    a_main_bits: assert property (p_main_bits)
        else $error("control_main spare bits");
    a_mode_bits: assert property (p_mode_bits)
        else $error("control_mode_output spare bits");
    a_evt_bits: assert property (p_evt_bits)
        else $error("event_control spare bits");
    a_flag_bits: assert property (p_flag_bits)
        else $error("interrupt_flag spare bits");
    a_run_bits: assert property (p_run_bits)
        else $error("run_state spare bits");
    a_pin_idle: assert property (p_pin_idle)
        else $error("pin level while released");
    c_capture: cover property (capture_event);
    c_driven: cover property (!wave_oe_b && wave_out);
    c_cmp_read: cover property (rdok && ix == 4'hC);
endmodule
bind sbct_timer sbct_timer_properties i_props (
    .clk             (clk),
    .rst_b           (rst_b),
    .avs_address     (avs_address),
    .avs_read        (avs_read),
    .avs_write       (avs_write),
    .avs_readdata    (avs_readdata),
    .avs_waitrequest (avs_waitrequest),
    .wave_out        (wave_out),
    .wave_oe_b       (wave_oe_b),
    .capture_event   (capture_event)
);
`default_nettype wire

// ==== bench/sbct_partner.sv ====
/*
 event routing and companion timer model.
 assumes requests from the bench, driven just after rising edges.
*/
`timescale 1ns/10ps
`default_nettype none
module sbct_partner (
    input  wire logic clk,
    input  wire logic rst_b,
    input  wire logic ev_req,
    input  wire logic restart_req,
    output var  logic event_in,
    output var  logic companion_tick,
    output var  logic companion_restart
);
    logic [1:0] div;
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            div <= 2'h0;
            event_in <= 1'h0;
            companion_tick <= 1'h0;
            companion_restart <= 1'h0;
        end else begin
            // request registered once, one cycle late, so short events pass unchanged
            event_in <= ev_req;
            companion_restart <= restart_req;
            div <= (div == 2'h2) ? 2'h0 : div + 2'h1;
            companion_tick <= (div == 2'h2);
        end
    end
endmodule
`default_nettype wire

// ==== bench/tb_top.sv ====
/*
 self-checking bench for sbct_timer.
 assumes the partner model drives the event and companion inputs.
*/
`timescale 1ns/10ps
`default_nettype none
module tb_top;
    logic        clk, rst_b, avs_read, avs_write, ev_req, restart_req, standby;
    logic [5:0]  avs_address;
    logic [31:0] avs_writedata, avs_readdata;
    logic [3:0]  avs_byteenable;
    logic        avs_waitrequest, event_in, companion_tick, companion_restart;
    logic        wave_out, wave_oe_b, capture_event;
    logic [7:0]  r, c1;
    int          err_count, comparisons, cap_n;
    // index, written byte, byte read back
    logic [19:0] regs [14] = '{20'h0FF57, 20'h00000, 20'h1FF77, 20'h10000,
        20'h4FF51, 20'h40000, 20'h5FF01, 20'h8FF01, 20'h9A5A5, 20'hC3434,
        20'hD1212, 20'h2FF00, 20'hEFF00, 20'h7FF00};
    // per edge bit and mode: run state, captures after rise, fall, rise
    logic [2:0]  mrow [16] = '{3'h4, 3'h4, 3'h6, 3'h6, 3'h5, 3'h1, 3'h4,
        3'h4, 3'h4, 3'h0, 3'h5, 3'h5, 3'h6, 3'h4, 3'h4, 3'h4};
    sbct_timer i_dut (.clk(clk), .rst_b(rst_b), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .event_in(event_in), .companion_tick(companion_tick),
        .companion_restart(companion_restart), .standby(standby),
        .wave_out(wave_out), .wave_oe_b(wave_oe_b),
        .capture_event(capture_event));
    sbct_partner i_partner (.clk(clk), .rst_b(rst_b), .ev_req(ev_req),
        .restart_req(restart_req), .event_in(event_in),
        .companion_tick(companion_tick),
        .companion_restart(companion_restart));
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    always @(posedge clk) if (capture_event === 1'b1) cap_n = cap_n + 1;
    task final_report;
        $display("counts: %0d compared, %0d wrong", comparisons, err_count);
        if (err_count == 0 && comparisons > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    task fail(input string m);
        err_count++;
        $display("wrong value at %0t: %s", $time, m);
    endtask
    task chk(input logic [15:0] g, input logic [15:0] e, input string m);
        comparisons++;
        if (g !== e) fail($sformatf("%s %h not %h", m, g, e));
    endtask
    task rng(input logic [7:0] g, input logic [7:0] lo, hi, input string m);
        comparisons++;
        if ((g >= lo && g <= hi) !== 1'b1) fail($sformatf("%s %h", m, g));
    endtask
    task bus(input logic wr, input logic [3:0] ix, input logic [7:0] wd);
        int n;
        n = 0;
        @(posedge clk);
        avs_address <= {ix, 2'h0};
        avs_write <= wr;
        avs_read <= !wr;
        avs_writedata <= {24'h0, wd};
        do begin
            @(posedge clk);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 40);
        if (n >= 40) fail("bus stuck");
        r = avs_readdata[7:0];
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask
    task ev(input logic v);
        @(posedge clk);
        ev_req <= v;
        // covers the filter delay with margin
        repeat (8) @(posedge clk);
    endtask
    task cfg(input logic [7:0] md, evc, input logic [15:0] top);
        bus(1, 4'h0, 8'h00);
        bus(1, 4'hA, 8'h00);
        bus(1, 4'hB, 8'h00);
        bus(1, 4'hC, top[7:0]);
        bus(1, 4'hD, top[15:8]);
        bus(1, 4'h1, md);
        bus(1, 4'h4, evc);
        bus(1, 4'h0, 8'h01);
        cap_n = 0;
    endtask
    task span(input logic [7:0] cm);
        bus(1, 4'h0, 8'h00);
        bus(1, 4'hA, 8'h00);
        bus(1, 4'h0, cm);
        repeat (60) @(posedge clk);
        bus(1, 4'h0, 8'h00);
        bus(0, 4'hA, 8'h00);
    endtask
    initial begin
        // a hang is cut off well past the expected few thousand cycles
        #500000;
        fail("watchdog");
        final_report;
    end
    initial begin
        {rst_b, avs_read, avs_write, ev_req, restart_req, standby} = 6'h0;
        {avs_address, avs_writedata} = 38'h0;
        avs_byteenable = 4'hF;
        {err_count, comparisons, cap_n} = 0;
        repeat (5) @(posedge clk);
        rst_b <= 1'b1;
        foreach (regs[i]) begin
            bus(1, regs[i][19:16], regs[i][15:8]);
            bus(0, regs[i][19:16], 8'h00);
            chk(r, regs[i][7:0], "register");
        end
        $display("test registers done");
        foreach (mrow[i]) begin
            cfg(8'(i[2:0]), {3'h0, i[3], 4'h1}, 16'hFFFF);
            ev(1);
            ev(0);
            ev(1);
            bus(0, 4'h7, 8'h00);
            chk(16'(cap_n), mrow[i][1:0], "captures");
            chk(r, mrow[i][2], "running");
            ev(0);
        end
        $display("test modes done");
        cfg(8'h00, 8'h01, 16'h0010);
        ev(1);
        ev(0);
        bus(1, 4'h0, 8'h00);
        bus(0, 4'h6, 8'h00);
        chk(r, 8'h01, "top flag");
        bus(0, 4'hC, 8'h00);
        chk(r, 8'h10, "top kept");
        bus(1, 4'h6, 8'h01);
        bus(0, 4'h6, 8'h00);
        chk(r, 8'h00, "flag write");
        cfg(8'h02, 8'h00, 16'hFFFF);
        ev(1);
        chk(16'(cap_n), 16'h0, "events off");
        bus(1, 4'h4, 8'h01);
        ev(0);
        ev(1);
        chk(16'(cap_n), 16'h1, "capture");
        bus(0, 4'hC, 8'h00);
        bus(0, 4'h6, 8'h00);
        chk(r, 8'h00, "read clear");
        ev(0);
        cfg(8'h02, 8'h41, 16'hFFFF);
        bus(1, 4'h6, 8'h01);
        ev_req <= 1'b1;
        repeat (2) @(posedge clk);
        ev_req <= 1'b0;
        ev(0);
        bus(0, 4'h6, 8'h00);
        chk(r, 8'h00, "glitch kept out");
        ev(1);
        bus(0, 4'h6, 8'h00);
        chk(r, 8'h01, "filtered edge");
        ev(0);
        $display("test flags done");
        cfg(8'h30, 8'h00, 16'hFFFF);
        chk({wave_oe_b, wave_out}, 2'h1, "pin high");
        cfg(8'h10, 8'h00, 16'hFFFF);
        chk({wave_oe_b, wave_out}, 2'h0, "pin low");
        cfg(8'h20, 8'h00, 16'hFFFF);
        chk({wave_oe_b, wave_out}, 2'h2, "pin off");
        cfg(8'h36, 8'h01, 16'hFFFF);
        chk({wave_oe_b, wave_out}, 2'h0, "shot idle");
        ev(1);
        chk({wave_oe_b, wave_out}, 2'h1, "shot high");
        ev(0);
        cfg(8'h56, 8'h01, 16'hFFFF);
        ev_req <= 1'b1;
        repeat (4) @(posedge clk);
        chk({wave_oe_b, wave_out}, 2'h1, "shot async");
        ev(0);
        $display("test output done");
        cfg(8'h00, 8'h00, 16'hFFFF);
        span(8'h01);
        c1 = r;
        rng(c1, 8'd58, 8'd70, "undivided");
        span(8'h03);
        rng(r, c1 / 2 - 1, c1 / 2 + 1, "half");
        span(8'h05);
        rng(r, c1 / 3 - 1, c1 / 3 + 1, "companion");
        standby <= 1'b1;
        span(8'h01);
        rng(r, 8'd0, 8'd0, "standby halt");
        span(8'h41);
        rng(r, c1 - 1, c1 + 1, "standby run");
        standby <= 1'b0;
        bus(1, 4'hA, 8'h00);
        bus(1, 4'h0, 8'h11);
        repeat (40) @(posedge clk);
        restart_req <= 1'b1;
        @(posedge clk);
        restart_req <= 1'b0;
        repeat (5) @(posedge clk);
        bus(1, 4'h0, 8'h00);
        bus(0, 4'hA, 8'h00);
        rng(r, 8'd1, 8'd14, "restart");
        $display("test clocks done");
        bus(1, 4'h1, 8'h37);
        rst_b <= 1'b0;
        repeat (2) @(posedge clk);
        chk({wave_oe_b, wave_out}, 2'h2, "reset pin");
        rst_b <= 1'b1;
        bus(0, 4'h1, 8'h00);
        chk(r, 8'h00, "reset mode");
        bus(0, 4'hC, 8'h00);
        chk(r, 8'h00, "reset compare");
        $display("test reset done");
        final_report;
    end
endmodule
`default_nettype wire
